// ---- pkg/spd_defines.svh ----
// Constants for the presence-detect EEPROM two-wire slave.
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// ----------------------------------------
// Select code and byte framing
// ----------------------------------------
`define SPD_SEL_MEM 4'hA
`define SPD_SEL_PROT 4'h6
`define SPD_BITS_PER_BYTE 4'h8
`define SPD_PAGE_BITS 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPD_PROG_TIME_MS 10
`define SPD_CLK_KHZ 10000

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define SPD_REG_CTRL 8'h00
`define SPD_REG_STATUS 8'h04
`define SPD_REG_MADDR 8'h08
`define SPD_REG_MDATA 8'h0C
`define SPD_REG_PROT 8'h10
`define SPD_CTRL_EN_RESET 1'b1
`define SPD_PROT_RESET 8'h00
`define SPD_SYNC_RESET 6'h3F

`endif

// ---- pkg/spd_pkg.sv ----
// Types shared by the presence-detect EEPROM slave.
package spd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVSEL,
    ST_DEVACK,
    ST_WADDR,
    ST_WADDRACK,
    ST_WDATA,
    ST_WDATAACK,
    ST_RDATA,
    ST_RACK,
    ST_WAITSTOP
  } spd_state_t;

endpackage : spd_pkg

// ---- hdl/spd_sync.sv ----
// Two-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
module spd_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage, never logic.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (srst) begin
        meta_q[i] <= RESET_VAL[i];
        sync_q[i] <= RESET_VAL[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_out = sync_q;

endmodule : spd_sync

// ---- hdl/spd_mem.sv ----
// Byte array with one write port and two registered read ports.
`timescale 1ns/1ps
module spd_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [DW-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_b
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_a_q;
  logic [DW-1:0] rdata_b_q;

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a_q <= mem[raddr_a];
    rdata_b_q <= mem[raddr_b];
  end

  assign rdata_a = rdata_a_q;
  assign rdata_b = rdata_b_q;

endmodule : spd_mem

// ---- hdl/spd_eeprom_slave.sv ----
// Two-wire presence-detect EEPROM slave with a register port.
`timescale 1ns/1ps
`include "spd_defines.svh"

module spd_eeprom_slave #(
  parameter int AW = 8,
  parameter int PROG_CYCLES = `SPD_PROG_TIME_MS * `SPD_CLK_KHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps and write control
  input wire logic write_control_pin,
  input wire logic strap_addr_bit2,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0
);

  localparam int BW = $clog2(PROG_CYCLES + 1);
  localparam int PB = `SPD_PAGE_BITS;

  if (PROG_CYCLES < 1 || AW != 8) begin : g_bad_param
    $error("spd_eeprom_slave: unsupported parameter values");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wc_s;
  logic [2:0] strap_s;

  spd_sync #(.WIDTH(6), .RESET_VAL(`SPD_SYNC_RESET)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({write_control_pin, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[4:2];
  assign wc_s = pins_s[5];

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  spd_pkg::spd_state_t state_q, state_d;
  logic scl_p_q, scl_p_d;
  logic sda_p_q, sda_p_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shr_q, shr_d;
  logic [7:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic [AW-1:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic prot_sel_q, prot_sel_d;
  logic wrote_q, wrote_d;
  logic acked_q, acked_d;
  logic [BW-1:0] busy_q, busy_d;
  logic [7:0] prot_q, prot_d;

  // Register-side state.
  logic en_q, en_d;
  logic [AW-1:0] maddr_q, maddr_d;
  logic [31:0] rdata_q, rdata_d;

  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;
  logic match_w;
  logic byte_end_w;
  logic i2c_we_w;
  logic bus_we_w;
  logic [7:0] mem_rd_bus;
  logic [7:0] mem_rd_link;
  logic [7:0] rbyte_w;

  assign scl_rise_w = scl_s & ~scl_p_q;
  assign scl_fall_w = ~scl_s & scl_p_q;
  assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign match_w = (shr_q[7:4] == `SPD_SEL_MEM || shr_q[7:4] == `SPD_SEL_PROT) && shr_q[3:1] == strap_s;
  assign byte_end_w = scl_fall_w && cnt_q == `SPD_BITS_PER_BYTE;
  assign rbyte_w = prot_sel_q ? prot_q : mem_rd_link;

  // ----------------------------------------
  // Link next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    scl_p_d = scl_s;
    sda_p_d = sda_s;
    cnt_d = cnt_q;
    shr_d = shr_q;
    tx_d = tx_q;
    oe_d = oe_q;
    addr_d = addr_q;
    rd_d = rd_q;
    prot_sel_d = prot_sel_q;
    wrote_d = wrote_q;
    acked_d = acked_q;
    prot_d = prot_q;
    i2c_we_w = 1'b0;
    busy_d = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
    if (stop_w) begin
      state_d = spd_pkg::ST_IDLE;
      oe_d = 1'b0;
      if (wrote_q) begin
        busy_d = BW'(PROG_CYCLES);
        wrote_d = 1'b0;
      end
    end else if (start_w) begin
      if (busy_q == '0 && en_q) begin
        state_d = spd_pkg::ST_DEVSEL;
      end else begin
        state_d = spd_pkg::ST_IDLE;
      end
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        spd_pkg::ST_DEVSEL, spd_pkg::ST_WADDR, spd_pkg::ST_WDATA: begin
          if (scl_rise_w) begin
            shr_d = {shr_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          if (byte_end_w) begin
            cnt_d = 4'h0;
            if (state_q == spd_pkg::ST_DEVSEL) begin
              if (match_w) begin
                rd_d = shr_q[0];
                prot_sel_d = shr_q[7:4] == `SPD_SEL_PROT;
                oe_d = 1'b1;
                state_d = spd_pkg::ST_DEVACK;
              end else begin
                state_d = spd_pkg::ST_IDLE;
              end
            end else if (state_q == spd_pkg::ST_WADDR) begin
              addr_d = shr_q;
              oe_d = 1'b1;
              state_d = spd_pkg::ST_WADDRACK;
            end else begin
              oe_d = 1'b1;
              state_d = spd_pkg::ST_WDATAACK;
              if (!wc_s) begin
                wrote_d = 1'b1;
                if (prot_sel_q) begin
                  prot_d = shr_q;
                end else begin
                  i2c_we_w = 1'b1;
                  addr_d = {addr_q[AW-1:PB], addr_q[PB-1:0] + 1'b1};
                end
              end
            end
          end
        end
        spd_pkg::ST_DEVACK, spd_pkg::ST_WADDRACK, spd_pkg::ST_WDATAACK: begin
          if (scl_fall_w) begin
            oe_d = 1'b0;
            if (state_q == spd_pkg::ST_DEVACK && rd_q) begin
              tx_d = rbyte_w;
              oe_d = ~rbyte_w[7];
              state_d = spd_pkg::ST_RDATA;
            end else if (state_q == spd_pkg::ST_DEVACK && !prot_sel_q) begin
              state_d = spd_pkg::ST_WADDR;
            end else begin
              state_d = spd_pkg::ST_WDATA;
            end
          end
        end
        spd_pkg::ST_RDATA: begin
          if (scl_rise_w) begin
            cnt_d = cnt_q + 4'h1;
          end
          if (byte_end_w) begin
            cnt_d = 4'h0;
            oe_d = 1'b0;
            acked_d = 1'b0;
            state_d = spd_pkg::ST_RACK;
          end else if (scl_fall_w) begin
            // drive next bit while clock low
            tx_d = {tx_q[6:0], 1'b1};
            oe_d = ~tx_q[6];
          end
        end
        spd_pkg::ST_RACK: begin
          if (scl_rise_w) begin
            if (!sda_s) begin
              acked_d = 1'b1;
              if (!prot_sel_q) begin
                addr_d = addr_q + 1'b1;
              end
            end else begin
              state_d = spd_pkg::ST_WAITSTOP;
            end
          end
          if (scl_fall_w && acked_q) begin
            tx_d = rbyte_w;
            oe_d = ~rbyte_w[7];
            state_d = spd_pkg::ST_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= spd_pkg::ST_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      cnt_q <= 4'h0;
      shr_q <= 8'h00;
      tx_q <= 8'hFF;
      oe_q <= 1'b0;
      addr_q <= '0;
      rd_q <= 1'b0;
      prot_sel_q <= 1'b0;
      wrote_q <= 1'b0;
      acked_q <= 1'b0;
      busy_q <= '0;
      prot_q <= `SPD_PROT_RESET;
    end else begin
      state_q <= state_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      cnt_q <= cnt_d;
      shr_q <= shr_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      prot_sel_q <= prot_sel_d;
      wrote_q <= wrote_d;
      acked_q <= acked_d;
      busy_q <= busy_d;
      prot_q <= prot_d;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // A bus write to the array loses to a link write in the same cycle; both are rare.
  assign bus_we_w = reg_we && reg_addr == `SPD_REG_MDATA && !i2c_we_w;

  always_comb begin
    en_d = en_q;
    maddr_d = maddr_q;
    rdata_d = 32'h0000_0000;
    if (reg_we) begin
      if (reg_addr == `SPD_REG_CTRL) begin
        en_d = reg_wdata[0];
      end else if (reg_addr == `SPD_REG_MADDR) begin
        maddr_d = reg_wdata[AW-1:0];
      end else if (reg_addr == `SPD_REG_MDATA) begin
        maddr_d = maddr_q + 1'b1;
      end
    end
    if (reg_re) begin
      if (reg_addr == `SPD_REG_CTRL) begin
        rdata_d = {31'h0, en_q};
      end else if (reg_addr == `SPD_REG_STATUS) begin
        rdata_d = {16'h0, addr_q, 5'h0, prot_sel_q, state_q != spd_pkg::ST_IDLE, busy_q != '0};
      end else if (reg_addr == `SPD_REG_MADDR) begin
        rdata_d = {24'h0, maddr_q};
      end else if (reg_addr == `SPD_REG_MDATA) begin
        rdata_d = {24'h0, mem_rd_bus};
      end else if (reg_addr == `SPD_REG_PROT) begin
        rdata_d = {24'h0, prot_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      en_q <= `SPD_CTRL_EN_RESET;
      maddr_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      en_q <= en_d;
      maddr_q <= maddr_d;
      rdata_q <= rdata_d;
    end
  end

  // Next address feeds the bus port so a read right after setting it is current.
  spd_mem #(.AW(AW), .DW(8)) u_mem (
    .clock(clock),
    .we(i2c_we_w | bus_we_w),
    .waddr(i2c_we_w ? addr_q : maddr_q),
    .wdata(i2c_we_w ? shr_q : reg_wdata[7:0]),
    .raddr_a(maddr_d),
    .rdata_a(mem_rd_bus),
    .raddr_b(addr_q),
    .rdata_b(mem_rd_link)
  );

  assign reg_rdata = rdata_q;
  assign sda_oe = oe_q;
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_read_acked;
    state_q == spd_pkg::ST_RACK && scl_rise_w && !sda_s && !start_w && !stop_w;
  endsequence

  sequence s_read_nacked;
    state_q == spd_pkg::ST_RACK && scl_rise_w && sda_s && !start_w && !stop_w;
  endsequence

  a_sda_when_low: assert property (($changed(oe_q) && !$past(start_w) && !$past(stop_w)) |-> !scl_s)
    else $error("data line changed while clock high");
  a_idle_ignores: assert property ((state_q == spd_pkg::ST_IDLE && !start_w) |=> state_q == spd_pkg::ST_IDLE)
    else $error("left idle without a start");
  a_stop_to_idle: assert property (stop_w |=> state_q == spd_pkg::ST_IDLE && !oe_q)
    else $error("stop did not return to idle");
  a_release_byte: assert property ((state_q == spd_pkg::ST_RDATA && byte_end_w && !start_w && !stop_w)
    |=> state_q == spd_pkg::ST_RACK && !oe_q)
    else $error("data line not released after eight bits");
  a_ack_held_low: assert property ((state_q inside {spd_pkg::ST_DEVACK, spd_pkg::ST_WADDRACK, spd_pkg::ST_WDATAACK})
    |-> oe_q)
    else $error("acknowledge not driven");
  a_select_acked: assert property ((state_q == spd_pkg::ST_DEVSEL && byte_end_w && match_w && !start_w && !stop_w)
    |=> state_q == spd_pkg::ST_DEVACK && oe_q)
    else $error("matching select not acknowledged");
  a_write_acked: assert property ((state_q == spd_pkg::ST_WDATA && byte_end_w && !start_w && !stop_w)
    |=> state_q == spd_pkg::ST_WDATAACK ##1 oe_q)
    else $error("write byte not acknowledged");
  a_read_advance: assert property ((s_read_acked ##0 !prot_sel_q) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("address did not advance after acknowledge");
  a_read_next: assert property ((state_q == spd_pkg::ST_RACK && acked_q && scl_fall_w && !start_w && !stop_w)
    |=> state_q == spd_pkg::ST_RDATA && tx_q == $past(rbyte_w))
    else $error("next read byte not started");
  a_nack_waits: assert property (s_read_nacked |=> state_q == spd_pkg::ST_WAITSTOP && !oe_q)
    else $error("transmission continued after no acknowledge");
  a_wc_blocks: assert property (i2c_we_w |-> !wc_s)
    else $error("array written with write control high");
  a_prog_deaf: assert property ((stop_w && wrote_q) |=> busy_q == BW'(PROG_CYCLES) ##1 state_q == spd_pkg::ST_IDLE)
    else $error("program cycle not started after write stop");

endmodule : spd_eeprom_slave

// ---- sim/spd_host_model.sv ----
// Behavioural two-wire bus master that faces the presence-detect slave.
`timescale 1ns/1ps
module spd_host_model (
  // Clock
  input wire logic clock,
  // Bus lines
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  // Four clocks a half period gives the 800 ns link clock.
  localparam int HALF = 4;

  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk

  // data moves while clock low.
  // The data line waits one clock after the clock falls, so the slave never sees both change together.
  task automatic clk_bit(input logic b, output logic s);
    wait_clk(1);
    sda_low <= ~b;
    wait_clk(HALF - 1);
    scl <= 1'h1;
    wait_clk(HALF / 2);
    s = sda_wire;
    wait_clk(HALF / 2);
    scl <= 1'h0;
  endtask : clk_bit

  task automatic start_cond();
    wait_clk(1);
    sda_low <= 1'h0;
    wait_clk(HALF - 1);
    scl <= 1'h1;
    wait_clk(HALF);
    sda_low <= 1'h1;
    wait_clk(HALF);
    scl <= 1'h0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(1);
    sda_low <= 1'h1;
    wait_clk(HALF - 1);
    scl <= 1'h1;
    wait_clk(HALF);
    sda_low <= 1'h0;
    wait_clk(HALF);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'h1, ack);
  endtask : send_byte

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'h1, s);
      d[i] = s;
    end
    clk_bit(nack, s);
  endtask : recv_byte
endmodule : spd_host_model

// ---- sim/presence_detect_eeprom_slave_tb_top.sv ----
// Self-checking bench for the presence-detect EEPROM slave.
`timescale 1ns/1ps
`include "spd_defines.svh"
module presence_detect_eeprom_slave_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int PROG = 50;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] SEL_W = {`SPD_SEL_MEM, STRAP, 1'h0};
  localparam logic [7:0] SEL_R = {`SPD_SEL_MEM, STRAP, 1'h1};
  logic clock, srst, reg_we, reg_re, wc, sda_wire, scl, sda_low, sda_out, sda_oe, ack;
  logic [7:0] reg_addr, rd;
  logic [31:0] reg_wdata, reg_rdata, rw;
  int err_count, check_count;

  // Open drain with pull-up: low while any party pulls.
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  spd_eeprom_slave #(.PROG_CYCLES(PROG)) i_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .write_control_pin(wc),
    .strap_addr_bit2(STRAP[2]), .strap_addr_bit1(STRAP[1]), .strap_addr_bit0(STRAP[0])
  );

  spd_host_model i_host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_re <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic reg_expect(input logic [7:0] a, input logic [31:0] exp, input string name);
    reg_read(a, rw);
    check(name, exp, rw);
  endtask : reg_expect

  task automatic put(input logic [7:0] d, input logic exp_ack, input string name);
    i_host.send_byte(d, ack);
    check(name, {31'h0, exp_ack}, {31'h0, ack});
  endtask : put

  task automatic get(input logic nack, input logic [7:0] exp, input string name);
    i_host.recv_byte(nack, rd);
    check(name, {24'h0, exp}, {24'h0, rd});
  endtask : get

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // The tests need about 2300 clocks; the margin covers a slow design.
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    $display("MISMATCH watchdog expected done seen hang");
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    srst = 1'h1;
    reg_we = 1'h0;
    reg_re = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    wc = 1'h0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    repeat (4) @(posedge clock);
    reg_expect(`SPD_REG_CTRL, 32'h1, "ctrl reset");
    reg_expect(`SPD_REG_PROT, 32'h0, "prot reset");
    reg_expect(8'h14, 32'h0, "unmapped read");
    reg_write(`SPD_REG_MADDR, 32'h10);
    reg_write(`SPD_REG_MDATA, 32'hC3);
    reg_write(`SPD_REG_MDATA, 32'h96);
    reg_write(`SPD_REG_MADDR, 32'h30);
    reg_write(`SPD_REG_MDATA, 32'hEE);
    put(SEL_W, 1'h1, "byte before start");
    i_host.start_cond();
    put(SEL_W, 1'h0, "select write ack");
    put(8'h10, 1'h0, "word address ack");
    i_host.start_cond();
    put(SEL_R, 1'h0, "select read ack");
    get(1'h0, 8'hC3, "random read");
    get(1'h1, 8'h96, "sequential read");
    i_host.clk_bit(1'h1, ack);
    check("released after nack", 32'h1, {31'h0, ack});
    i_host.stop_cond();
    reg_expect(`SPD_REG_STATUS, 32'h1100, "idle after stop");
    i_host.start_cond();
    put(SEL_R, 1'h0, "current select ack");
    get(1'h1, 8'h96, "current read");
    i_host.stop_cond();
    i_host.start_cond();
    put({`SPD_SEL_MEM, ~STRAP, 1'h0}, 1'h1, "strap mismatch");
    put(8'h00, 1'h1, "ignored byte");
    i_host.stop_cond();
    i_host.start_cond();
    put(SEL_W, 1'h0, "page select ack");
    put(8'h2F, 1'h0, "page address ack");
    put(8'h5A, 1'h0, "page byte0 ack");
    put(8'hA5, 1'h0, "page byte1 ack");
    i_host.stop_cond();
    reg_read(`SPD_REG_STATUS, rw);
    check("busy after write", 32'h1, {31'h0, rw[0]});
    i_host.start_cond();
    put(SEL_W, 1'h1, "deaf while busy");
    i_host.stop_cond();
    repeat (PROG + 10) @(posedge clock);
    reg_write(`SPD_REG_MADDR, 32'h2F);
    reg_expect(`SPD_REG_MDATA, 32'h5A, "page byte0 stored");
    reg_write(`SPD_REG_MADDR, 32'h20);
    reg_expect(`SPD_REG_MDATA, 32'hA5, "page wrap stored");
    wc <= 1'h1;
    i_host.start_cond();
    put(SEL_W, 1'h0, "locked select ack");
    put(8'h30, 1'h0, "locked address ack");
    put(8'h11, 1'h0, "locked data ack");
    i_host.stop_cond();
    wc <= 1'h0;
    repeat (PROG + 10) @(posedge clock);
    reg_write(`SPD_REG_MADDR, 32'h30);
    reg_expect(`SPD_REG_MDATA, 32'hEE, "locked byte kept");
    i_host.start_cond();
    put({`SPD_SEL_PROT, STRAP, 1'h0}, 1'h0, "prot select ack");
    put(8'h3C, 1'h0, "prot data ack");
    reg_expect(`SPD_REG_STATUS, 32'h3006, "prot busy status");
    i_host.stop_cond();
    repeat (PROG + 10) @(posedge clock);
    reg_expect(`SPD_REG_PROT, 32'h3C, "prot written");
    i_host.start_cond();
    put({`SPD_SEL_PROT, STRAP, 1'h1}, 1'h0, "prot read select");
    get(1'h1, 8'h3C, "prot read");
    i_host.stop_cond();
    reg_write(`SPD_REG_CTRL, 32'h0);
    reg_expect(`SPD_REG_CTRL, 32'h0, "ctrl cleared");
    i_host.start_cond();
    put(SEL_R, 1'h1, "disabled ignores");
    i_host.stop_cond();
    reg_write(`SPD_REG_CTRL, 32'h1);
    i_host.start_cond();
    put(SEL_R, 1'h0, "enabled select ack");
    get(1'h1, 8'hEE, "enabled current read");
    i_host.stop_cond();
    summarize();
  end
endmodule : presence_detect_eeprom_slave_tb_top
